//--- core/mbp_pkg.sv
// constants and types shared by the host-side bus port controller
`default_nettype none
package mbp_pkg;
  localparam int ADDR_W = 20;
  localparam int BYTE_W = 8;
  // bus wiring modes
  localparam logic [1:0] MODE_MUX = 2'h0;
  localparam logic [1:0] MODE_SEP = 2'h1;
  localparam logic [1:0] MODE_PAGE = 2'h2;
  localparam logic [1:0] MODE_BURST = 2'h3;
  // phase lengths, nanoseconds, and cycles at 250 MHz
  localparam int CLK_NS = 4;
  localparam int ADDR_NS = 12;
  localparam int STROBE_NS = 40;
  localparam int HOLD_NS = 8;
  localparam int RESET_NS = 200;
  localparam logic [7:0] ADDR_CYC = 8'((ADDR_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] STROBE_CYC = 8'((STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] HOLD_CYC = 8'((HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] RESET_CYC = 8'((RESET_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  typedef enum logic [5:0] {
    ST_RESET = 6'h01,
    ST_IDLE = 6'h02,
    ST_ADDR = 6'h04,
    ST_TURN = 6'h08,
    ST_STROBE = 6'h10,
    ST_HOLD = 6'h20
  } mbp_state_e;
endpackage
`default_nettype wire

//--- core/mbp_lane.sv
// one 8-bit address/data lane: picks address or data byte for the current phase
`default_nettype none
module mbp_lane (
  // selection
  input wire logic addrPhase,
  input wire logic dataShared,
  input wire logic isWrite,
  // bytes
  input wire logic [7:0] addrByte,
  input wire logic [7:0] dataByte,
  // pin drive
  output logic [7:0] outByte,
  output logic outEnable
);
  // a lane that shares data drives during address and on writes only;
  // on reads it is released so the device can answer on the same pins
  always_comb begin
    outByte = addrPhase ? addrByte : (dataShared ? dataByte : addrByte);
    outEnable = addrPhase | ~dataShared | isWrite;
  end
endmodule
`default_nettype wire

//--- core/mbp_host_port.sv
// host controller that drives the companion chip's address/data ports and controls
`default_nettype none
module mbp_host_port (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // configuration
  input wire logic [1:0] busMode,
  input wire logic rwSelectMode,
  input wire logic fetchOnRead,
  // request
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic reqFetch,
  input wire logic [19:0] reqAddr,
  input wire logic [15:0] reqWdata,
  output logic reqReady,
  output logic rspValid,
  output logic [15:0] rspRdata,
  // low port pins
  input wire logic [7:0] lowPortIn,
  output logic [7:0] lowPortOut,
  output logic lowPortOe,
  // high port pins
  input wire logic [7:0] highPortIn,
  output logic [7:0] highPortOut,
  output logic highPortOe,
  // separate data bus pins
  input wire logic [7:0] dataPortIn,
  output logic [7:0] dataPortOut,
  output logic dataPortOe,
  // controls
  output logic addressValidStrobe,
  output logic writeControlInput,
  output logic readControlInput,
  output logic fetchControlInput,
  output logic resetN
);
  mbp_pkg::mbp_state_e state, next_state;
  logic [7:0] count, next_count;
  logic [19:0] addr, next_addr;
  logic [15:0] wdata, next_wdata;
  logic isWrite, next_isWrite, isFetch, next_isFetch;
  logic [7:0] next_lowPortOut, next_highPortOut, next_dataPortOut;
  logic next_lowPortOe, next_highPortOe, next_dataPortOe;
  logic next_addressValidStrobe, next_writeControlInput, next_readControlInput;
  logic next_fetchControlInput, next_resetN, next_reqReady, next_rspValid;
  logic [15:0] next_rspRdata;
  logic [7:0] lowAddr, highAddr, lowData, highData, lowDrv, highDrv;
  logic lowShared, highShared, lowEn, highEn, addrPhase, strobeOn;

  // which lane shares pins with data in each wiring
  function automatic logic laneShared(input logic [1:0] m, input logic high);
    if (m == mbp_pkg::MODE_MUX) laneShared = ~high;
    else if (m == mbp_pkg::MODE_SEP) laneShared = 1'b0;
    else if (m == mbp_pkg::MODE_PAGE) laneShared = high;
    else laneShared = 1'b1;
  endfunction

  always_comb begin
    lowShared = laneShared(busMode, 1'b0);
    highShared = laneShared(busMode, 1'b1);
    // burst wiring shifts the address down by four bits
    if (busMode == mbp_pkg::MODE_BURST) begin
      lowAddr = addr[11:4];
      highAddr = addr[19:12];
    end else begin
      lowAddr = addr[7:0];
      highAddr = addr[15:8];
    end
    // page mode carries data on the high lane only
    lowData = wdata[7:0];
    highData = (busMode == mbp_pkg::MODE_PAGE) ? wdata[7:0] : wdata[15:8];
  end

  mbp_lane lowLane (
    .addrPhase(addrPhase),
    .dataShared(lowShared),
    .isWrite(isWrite),
    .addrByte(lowAddr),
    .dataByte(lowData),
    .outByte(lowDrv),
    .outEnable(lowEn)
  );

  mbp_lane highLane (
    .addrPhase(addrPhase),
    .dataShared(highShared),
    .isWrite(isWrite),
    .addrByte(highAddr),
    .dataByte(highData),
    .outByte(highDrv),
    .outEnable(highEn)
  );

  always_comb begin
    next_state = state;
    next_count = count;
    next_addr = addr;
    next_wdata = wdata;
    next_isWrite = isWrite;
    next_isFetch = isFetch;
    next_rspValid = 1'b0;
    next_rspRdata = rspRdata;
    next_resetN = 1'b1;
    addrPhase = 1'b0;
    strobeOn = 1'b0;
    case (state)
      mbp_pkg::ST_RESET: begin
        // device reset held low from power-up for a fixed time
        next_resetN = 1'b0;
        next_count = count - mbp_pkg::CNT_ONE;
        if (count == mbp_pkg::CNT_ONE) begin
          next_state = mbp_pkg::ST_IDLE;
          next_resetN = 1'b1;
        end
      end
      mbp_pkg::ST_IDLE: begin
        if (reqValid) begin
          next_addr = reqAddr;
          next_wdata = reqWdata;
          next_isWrite = reqWrite;
          next_isFetch = reqFetch & ~reqWrite;
          next_count = mbp_pkg::ADDR_CYC;
          next_state = mbp_pkg::ST_ADDR;
        end
      end
      mbp_pkg::ST_ADDR: begin
        addrPhase = 1'b1;
        next_count = count - mbp_pkg::CNT_ONE;
        if (count == mbp_pkg::CNT_ONE) begin
          next_state = mbp_pkg::ST_TURN;
        end
      end
      mbp_pkg::ST_TURN: begin
        // one cycle so shared pins are released before the device answers
        next_count = mbp_pkg::STROBE_CYC;
        next_state = mbp_pkg::ST_STROBE;
      end
      mbp_pkg::ST_STROBE: begin
        strobeOn = 1'b1;
        next_count = count - mbp_pkg::CNT_ONE;
        if (count == mbp_pkg::CNT_ONE) begin
          // sample at the end of the strobe, before the device lets go
          if (!isWrite) begin
            next_rspRdata[7:0] = lowShared ? lowPortIn : (highShared ? highPortIn : dataPortIn);
            next_rspRdata[15:8] = (busMode == mbp_pkg::MODE_BURST) ? highPortIn : 8'h00;
          end
          next_rspValid = 1'b1;
          next_count = mbp_pkg::HOLD_CYC;
          next_state = mbp_pkg::ST_HOLD;
        end
      end
      mbp_pkg::ST_HOLD: begin
        next_count = count - mbp_pkg::CNT_ONE;
        if (count == mbp_pkg::CNT_ONE) begin
          next_state = mbp_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = mbp_pkg::ST_IDLE;
      end
    endcase
    next_reqReady = (next_state == mbp_pkg::ST_IDLE);
  end

  always_comb begin
    next_addressValidStrobe = addrPhase;
    next_lowPortOut = lowDrv;
    next_highPortOut = highDrv;
    next_lowPortOe = 1'b0;
    next_highPortOe = 1'b0;
    next_dataPortOut = wdata[7:0];
    next_dataPortOe = 1'b0;
    if (state != mbp_pkg::ST_RESET && state != mbp_pkg::ST_IDLE) begin
      next_lowPortOe = lowEn;
      next_highPortOe = highEn;
      next_dataPortOe = (busMode == mbp_pkg::MODE_SEP) & isWrite;
    end
    // first control: write strobe, or read/write select high for read
    if (rwSelectMode) next_writeControlInput = ~isWrite | (state == mbp_pkg::ST_IDLE);
    else next_writeControlInput = ~(strobeOn & isWrite);
    // second control is an active-low read or data strobe; fetch enable has its own output
    if (rwSelectMode) next_readControlInput = ~strobeOn;
    else next_readControlInput = ~(strobeOn & ~isWrite & (~isFetch | fetchOnRead));
    next_fetchControlInput = ~(strobeOn & isFetch & ~fetchOnRead);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= mbp_pkg::ST_RESET;
      count <= mbp_pkg::RESET_CYC;
      addr <= '0;
      wdata <= '0;
      isWrite <= 1'b0;
      isFetch <= 1'b0;
      reqReady <= 1'b0;
      rspValid <= 1'b0;
      rspRdata <= '0;
      lowPortOut <= '0;
      highPortOut <= '0;
      dataPortOut <= '0;
      lowPortOe <= 1'b0;
      highPortOe <= 1'b0;
      dataPortOe <= 1'b0;
      addressValidStrobe <= 1'b0;
      writeControlInput <= 1'b1;
      readControlInput <= 1'b1;
      fetchControlInput <= 1'b1;
      resetN <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      addr <= next_addr;
      wdata <= next_wdata;
      isWrite <= next_isWrite;
      isFetch <= next_isFetch;
      reqReady <= next_reqReady;
      rspValid <= next_rspValid;
      rspRdata <= next_rspRdata;
      lowPortOut <= next_lowPortOut;
      highPortOut <= next_highPortOut;
      dataPortOut <= next_dataPortOut;
      lowPortOe <= next_lowPortOe;
      highPortOe <= next_highPortOe;
      dataPortOe <= next_dataPortOe;
      addressValidStrobe <= next_addressValidStrobe;
      writeControlInput <= next_writeControlInput;
      readControlInput <= next_readControlInput;
      fetchControlInput <= next_fetchControlInput;
      resetN <= next_resetN;
    end
  end

  a_reset_held: assert property (@(posedge clock) disable iff (rst)
    $rose(resetN) |-> $past(resetN) == 1'b0 && $past(state) == mbp_pkg::ST_RESET)
    else $error("device reset released outside reset phase");
  a_mux_low_release: assert property (@(posedge clock) disable iff (rst)
    (busMode == mbp_pkg::MODE_MUX && !readControlInput && !isWrite) |-> !lowPortOe)
    else $error("low port driven during multiplexed read");
  a_sep_addr_only: assert property (@(posedge clock) disable iff (rst)
    (busMode == mbp_pkg::MODE_SEP && state != mbp_pkg::ST_IDLE && state != mbp_pkg::ST_RESET
     && $past(state) != mbp_pkg::ST_IDLE) |-> lowPortOe && highPortOe)
    else $error("address lane released in separate-bus mode");
  a_page_lanes: assert property (@(posedge clock) disable iff (rst)
    (busMode == mbp_pkg::MODE_PAGE && !readControlInput && !isWrite) |-> lowPortOe && !highPortOe)
    else $error("page-mode lane drive wrong during read");
  a_burst_addr: assert property (@(posedge clock) disable iff (rst)
    (busMode == mbp_pkg::MODE_BURST && $rose(addressValidStrobe)) |-> lowPortOut == addr[11:4]
     && highPortOut == addr[19:12])
    else $error("burst address bits misplaced");
  a_strobe_len: assert property (@(posedge clock) disable iff (rst)
    $rose(addressValidStrobe) |-> addressValidStrobe[*3] ##1 !addressValidStrobe)
    else $error("address strobe length wrong");
  a_rw_select: assert property (@(posedge clock) disable iff (rst)
    (rwSelectMode && !readControlInput) |-> writeControlInput == ~isWrite)
    else $error("read/write select level wrong");
  a_read_strobe_len: assert property (@(posedge clock) disable iff (rst)
    $fell(readControlInput) |-> !readControlInput[*8] ##1 !readControlInput[*2] ##1 readControlInput)
    else $error("read strobe length wrong");
  a_fetch_route: assert property (@(posedge clock) disable iff (rst)
    !fetchControlInput |-> !fetchOnRead && isFetch && readControlInput)
    else $error("fetch enable asserted without a code fetch");
endmodule
`default_nettype wire

//--- verification/mbp_device_model.sv
// behavioural companion chip bus port, seen from the host pins
`default_nettype none
module mbp_device_model (
  // clock and device reset
  input wire logic clock,
  input wire logic resetN,
  // device configuration
  input wire logic [1:0] busMode,
  input wire logic rwSelectMode,
  input wire logic fetchOnRead,
  // host pin drive
  input wire logic [7:0] lowPortOut,
  input wire logic lowPortOe,
  input wire logic [7:0] highPortOut,
  input wire logic highPortOe,
  input wire logic [7:0] dataPortOut,
  input wire logic dataPortOe,
  input wire logic addressValidStrobe,
  input wire logic writeControlInput,
  input wire logic readControlInput,
  input wire logic fetchControlInput,
  // resolved pin levels
  output logic [7:0] lowPortIn,
  output logic [7:0] highPortIn,
  output logic [7:0] dataPortIn,
  // what the device saw
  output logic [19:0] latchedAddr,
  output logic [15:0] writtenData
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] lastLow = 8'h00;
  logic [7:0] lastHigh = 8'h00;
  logic [7:0] lastData = 8'h00;
  logic rdAct, wrAct, sel, burst, lowOe, highOe, dataOe;
  logic [15:0] rv;
  assign burst = busMode == mbp_pkg::MODE_BURST;
  assign rdAct = rwSelectMode ? (writeControlInput & ~readControlInput)
    : (~readControlInput | (~fetchOnRead & ~fetchControlInput));
  assign wrAct = ~writeControlInput & (~rwSelectMode | ~readControlInput);
  // top 4k of each 64k window has no function behind it
  assign sel = latchedAddr[15:12] != 4'hF;
  assign rv = latchedAddr[15:0] ^ 16'hA5C3;
  assign lowOe = rdAct & sel & (busMode == mbp_pkg::MODE_MUX || burst);
  assign highOe = rdAct & sel & (busMode == mbp_pkg::MODE_PAGE || burst);
  assign dataOe = rdAct & sel & (busMode == mbp_pkg::MODE_SEP);
  // a released lane shows the inverse of its last level, never a handy zero
  assign lowPortIn = lowPortOe ? lowPortOut : lowOe ? rv[7:0] : ~lastLow;
  assign highPortIn = highPortOe ? highPortOut : highOe ? (burst ? rv[15:8] : rv[7:0]) : ~lastHigh;
  assign dataPortIn = dataPortOe ? dataPortOut : dataOe ? rv[7:0] : ~lastData;
  always @(posedge clock) begin
    if (lowPortOe | lowOe) lastLow <= lowPortIn;
    if (highPortOe | highOe) lastHigh <= highPortIn;
    if (dataPortOe | dataOe) lastData <= dataPortIn;
  end
  always @(posedge clock or negedge resetN) begin
    if (!resetN) begin
      latchedAddr <= 20'h00000;
      writtenData <= 16'h0000;
    end else begin
      if (addressValidStrobe) begin
        latchedAddr <= burst ? {highPortIn, lowPortIn, 4'h0} : {4'h0, highPortIn, lowPortIn};
      end
      if (wrAct) begin
        writtenData <= burst ? {highPortIn, lowPortIn} : {8'h00, busMode == mbp_pkg::MODE_PAGE ? highPortIn
          : busMode == mbp_pkg::MODE_SEP ? dataPortIn : lowPortIn};
      end
    end
  end
endmodule
`default_nettype wire

//--- verification/mcu_address_data_bus_port_bench.sv
// self-checking bench for the host-side bus port controller
`default_nettype none
module mcu_address_data_bus_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [1:0] busMode = 2'h0;
  logic rwSelectMode = 1'b0;
  logic fetchOnRead = 1'b0;
  logic reqValid = 1'b0;
  logic reqWrite = 1'b0;
  logic reqFetch = 1'b0;
  logic [19:0] reqAddr = 20'h00000;
  logic [15:0] reqWdata = 16'h0000;
  logic reqReady, rspValid, lowPortOe, highPortOe, dataPortOe;
  logic addressValidStrobe, writeControlInput, readControlInput, fetchControlInput, resetN;
  logic [15:0] rspRdata, writtenData;
  logic [7:0] lowPortIn, lowPortOut, highPortIn, highPortOut, dataPortIn, dataPortOut;
  logic [19:0] latchedAddr;
  int num_errors = 0;
  int num_checks = 0;
  mbp_host_port mbp_host_port_i (.clock(clock), .rst(rst), .busMode(busMode), .rwSelectMode(rwSelectMode),
    .fetchOnRead(fetchOnRead), .reqValid(reqValid), .reqWrite(reqWrite), .reqFetch(reqFetch),
    .reqAddr(reqAddr), .reqWdata(reqWdata), .reqReady(reqReady), .rspValid(rspValid), .rspRdata(rspRdata),
    .lowPortIn(lowPortIn), .lowPortOut(lowPortOut), .lowPortOe(lowPortOe), .highPortIn(highPortIn),
    .highPortOut(highPortOut), .highPortOe(highPortOe), .dataPortIn(dataPortIn), .dataPortOut(dataPortOut),
    .dataPortOe(dataPortOe), .addressValidStrobe(addressValidStrobe), .writeControlInput(writeControlInput),
    .readControlInput(readControlInput), .fetchControlInput(fetchControlInput), .resetN(resetN));
  mbp_device_model mbp_device_model_i (.clock(clock), .resetN(resetN), .busMode(busMode),
    .rwSelectMode(rwSelectMode), .fetchOnRead(fetchOnRead), .lowPortOut(lowPortOut), .lowPortOe(lowPortOe),
    .highPortOut(highPortOut), .highPortOe(highPortOe), .dataPortOut(dataPortOut), .dataPortOe(dataPortOe),
    .addressValidStrobe(addressValidStrobe), .writeControlInput(writeControlInput),
    .readControlInput(readControlInput), .fetchControlInput(fetchControlInput), .lowPortIn(lowPortIn),
    .highPortIn(highPortIn), .dataPortIn(dataPortIn), .latchedAddr(latchedAddr), .writtenData(writtenData));
  initial begin
    forever #2 clock = ~clock;
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [19:0] got, input logic [19:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    while (reqReady !== 1'b1 && n < 100) begin
      @(posedge clock);
      #1;
      n++;
    end
  endtask
  // entered with rst high; reset is held 12 cycles, then the device reset must trail it
  task automatic release_reset;
    int n;
    repeat (12) @(posedge clock);
    #1;
    check({19'h00000, resetN}, 20'h00000);
    check({17'h00000, lowPortOe, highPortOe, dataPortOe}, 20'h00000);
    rst = 1'b0;
    n = 0;
    while (resetN !== 1'b1 && n < 200) begin
      @(posedge clock);
      #1;
      n++;
    end
    check(20'(n), 20'(mbp_pkg::RESET_CYC));
    check({19'h00000, reqReady}, 20'h00001);
  endtask
  task automatic access(input logic w, input logic f, input logic [19:0] a, input logic [15:0] wd,
    output logic [15:0] rd);
    int n;
    reqWrite = w;
    reqFetch = f;
    reqAddr = a;
    reqWdata = wd;
    reqValid = 1'b1;
    wait_ready();
    @(posedge clock);
    #1;
    reqValid = 1'b0;
    n = 1;
    while (rspValid !== 1'b1 && n < 40) begin
      @(posedge clock);
      #1;
      n++;
    end
    check(20'(n), 20'h0000F);
    rd = rspRdata;
  endtask
  // write then read one address in the current mode and judge both ends
  task automatic rw_pair(input logic [19:0] a, input logic [15:0] wd, input logic f);
    logic [15:0] rd, rv;
    logic [19:0] la;
    logic b;
    b = busMode == mbp_pkg::MODE_BURST;
    la = b ? {a[19:4], 4'h0} : {4'h0, a[15:0]};
    rv = la[15:0] ^ 16'hA5C3;
    access(1'b1, 1'b0, a, wd, rd);
    check(latchedAddr, la);
    check({4'h0, writtenData}, b ? {4'h0, wd} : {12'h000, wd[7:0]});
    access(1'b0, f, a, 16'h0000, rd);
    check({4'h0, rd}, b ? {4'h0, rv} : {12'h000, rv[7:0]});
    wait_ready();
  endtask
  task automatic test_modes;
    for (int m = 0; m < 4; m++) begin
      busMode = 2'(m);
      rw_pair(20'h92B6D + 20'(m * 64), 16'hC3A5 ^ 16'(m), 1'b0);
    end
    $display("test_modes done");
  endtask
  task automatic test_rwsel;
    rwSelectMode = 1'b1;
    busMode = mbp_pkg::MODE_MUX;
    rw_pair(20'h1A55A, 16'h3C96, 1'b0);
    busMode = mbp_pkg::MODE_BURST;
    rw_pair(20'h7E0F1, 16'hF00F, 1'b0);
    rwSelectMode = 1'b0;
    $display("test_rwsel done");
  endtask
  task automatic test_fetch;
    busMode = mbp_pkg::MODE_MUX;
    for (int k = 0; k < 2; k++) begin
      fetchOnRead = k[0];
      rw_pair(20'h04321 + 20'(k * 4096), 16'h00A9, 1'b1);
    end
    fetchOnRead = 1'b0;
    $display("test_fetch done");
  endtask
  task automatic test_unselected;
    logic [15:0] rd;
    busMode = mbp_pkg::MODE_MUX;
    access(1'b0, 1'b0, 20'h0F123, 16'h0000, rd);
    check({4'h0, rd}, 20'h000DC);
    wait_ready();
    $display("test_unselected done");
  endtask
  task automatic test_midreset;
    busMode = mbp_pkg::MODE_BURST;
    reqWrite = 1'b1;
    reqAddr = 20'h55550;
    reqValid = 1'b1;
    repeat (7) @(posedge clock);
    #1;
    reqValid = 1'b0;
    rst = 1'b1;
    #1;
    check({16'h0000, lowPortOe, highPortOe, addressValidStrobe, resetN}, 20'h00000);
    check({17'h00000, writeControlInput, readControlInput, fetchControlInput}, 20'h00007);
    check(latchedAddr, 20'h00000);
    release_reset();
    // the port must carry on normally after a cut transfer
    rw_pair(20'h3C5A0, 16'h5AA5, 1'b0);
    $display("test_midreset done");
  endtask
  initial begin
    #20000;
    num_errors++;
    stop_test();
  end
  initial begin
    release_reset();
    test_modes();
    test_rwsel();
    test_fetch();
    test_unselected();
    test_midreset();
    stop_test();
  end
endmodule
`default_nettype wire
